// ---- include/bfp_defines.vh ----
// constants for the boot flash protection checker
// ==========================================================
// Summary of operation
// - lock bits may be programmed by software; only chip erase unprograms them
// - general write lock never blocks self-programming store writes
// - general read/write lock never restricts store or load accesses
// - lock and fuse bits: 1 unprogrammed, 0 programmed
// - application lock bits both 1: no application section restriction
// - application upper 1 lower 0, or both 0: store writes to application refused
// - application upper 0: loads from boot section reading application refused
// - application upper 0, vectors in boot: interrupts off while in application
// - boot lock bits both 1: no boot section restriction
// - boot upper 1 lower 0, or both 0: store writes to boot section refused
// - boot upper 0: loads from application reading boot section refused
// - boot upper 0, vectors in application: interrupts off while in boot
// - reset fuse 1 gives vector 0x0000, fuse 0 gives boot loader start
// - fuses cannot be changed by processor instructions
// - pointer low bits select word in page, high bits select page
// - pointer address latched when a programming operation starts
// - lock setting store ignores the pointer entirely
// - loads address bytes, pointer bit 0 picks low or high byte
// - store programming allowed only when executing from boot loader section
`ifndef BFP_DEFINES_VH
`define BFP_DEFINES_VH

// ==========================================================
// pointer and address layout
`define BFP_PTR_W        16
`define BFP_WADDR_W      15
`define BFP_WORD_BITS    6
`define BFP_PAGE_W       9
`define BFP_RESET_VECTOR 15'h0000
`define BFP_BOOT_START   15'h1c00

// ==========================================================
// lock and fuse encodings
`define BFP_PROGRAMMED   1'b0
`define BFP_LOCK_ERASED  2'b11
`define BFP_LOCK_W       6

// ==========================================================
// store operation codes
`define BFP_OP_W         2
`define BFP_OP_LOAD_BUF  2'h0
`define BFP_OP_ERASE     2'h1
`define BFP_OP_WRITE     2'h2
`define BFP_OP_LOCK      2'h3

// ==========================================================
// apb register map
`define BFP_REG_LOCK     12'h000
`define BFP_REG_FUSE     12'h004
`define BFP_REG_STATUS   12'h008
`define BFP_REG_ERASE    12'h00c
`define BFP_ERASE_KEY    32'h000000e5

`endif

// ---- tb/bfp_chk.sv ----
// concurrent checks on the boot flash protection ports
`timescale 1ns/1ps
`include "bfp_defines.vh"
module bfp_chk (
	input wire        pclk,
	input wire        presetn,
	input wire [14:0] cpu_pc,
	input wire        cpu_ivec_in_boot,
	input wire [7:0]  addr_pointer_high,
	input wire [7:0]  addr_pointer_low,
	input wire        store_program_memory_instr,
	input wire [1:0]  store_op,
	input wire        load_instr,
	input wire        store_grant,
	input wire        store_refused,
	input wire [8:0]  page_select_bits,
	input wire [5:0]  word_in_page_bits,
	input wire [14:0] load_word_addr,
	input wire        load_byte_high,
	input wire        irq_block,
	input wire [14:0] reset_vector
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// store answers: exactly one pulse, never from application code
	AST_STORE_ONCE: assert property (store_program_memory_instr |=>
		store_grant ^ store_refused) else $error("store answer count");
	AST_STORE_APP: assert property (store_program_memory_instr &&
		cpu_pc < `BFP_BOOT_START |=> store_refused) else $error("store from app");
	// ==========================================================
	// page and word latched on a grant of a non-lock store, held otherwise
	AST_PAGE: assert property (store_grant && $past(store_op) != 2'h3 |->
		{page_select_bits, word_in_page_bits} == $past({addr_pointer_high,
		addr_pointer_low[7:1]})) else $error("page split");
	AST_LOCK_PTR: assert property (store_grant && $past(store_op) == 2'h3 |->
		$stable({page_select_bits, word_in_page_bits})) else $error("lock op moved page");
	AST_PAGE_HOLD: assert property (!store_grant |->
		$stable({page_select_bits, word_in_page_bits})) else $error("page not held");
	AST_LOAD_ADDR: assert property (load_instr |=> {load_word_addr, load_byte_high} ==
		$past({addr_pointer_high, addr_pointer_low})) else $error("load byte address");
	// ==========================================================
	// interrupts only blocked away from the vector section
	AST_IRQ: assert property (irq_block |->
		(cpu_pc < `BFP_BOOT_START) == cpu_ivec_in_boot) else $error("irq block place");
	AST_RVEC: assert property (reset_vector == `BFP_RESET_VECTOR ||
		reset_vector == `BFP_BOOT_START) else $error("reset vector value");
endmodule

// ---- tb/bfp_cpu_model.sv ----
// cpu core model issuing program memory store and load instructions
`timescale 1ns/1ps
module bfp_cpu_model (
	input  wire        pclk,
	output reg  [14:0] cpu_pc,
	output reg  [7:0]  addr_pointer_high,
	output reg  [7:0]  addr_pointer_low,
	output reg         store_program_memory_instr,
	output reg  [1:0]  store_op,
	output reg  [7:0]  store_lock_data,
	output reg         load_instr
);
	initial {cpu_pc, addr_pointer_high, addr_pointer_low, store_op, store_lock_data} = 0;
	initial {store_program_memory_instr, load_instr} = 2'b00;
	// one instruction pulse; the answer is registered, seen after the next edge
	task automatic issue(input [14:0] pc, input [15:0] ptr, input ld, input [1:0] op,
		input [7:0] d);
		@(posedge pclk);
		cpu_pc <= pc;
		{addr_pointer_high, addr_pointer_low} <= ptr;
		{store_op, store_lock_data} <= {op, d};
		store_program_memory_instr <= !ld;
		load_instr <= ld;
		@(posedge pclk);
		{store_program_memory_instr, load_instr} <= 2'b00;
		// pointer reused at once, the latched copy must not follow
		{addr_pointer_high, addr_pointer_low} <= ~ptr;
		#1;
	endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the boot flash protection block
`timescale 1ns/1ps
`include "bfp_defines.vh"
module tb_top;
	reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	reg  [11:0] paddr = 0;
	reg  [31:0] pwdata = 0, rd;
	reg  [1:0]  nv_app_lock = 3, nv_boot_lock = 3, nv_gen_lock = 0;
	reg         nv_boot_reset_select_fuse = 1, cpu_ivec_in_boot = 0;
	wire        pready, pslverr, store_grant, store_refused, load_grant, load_refused;
	wire        load_byte_high, irq_block, store_program_memory_instr, load_instr;
	wire [31:0] prdata;
	wire [14:0] cpu_pc, load_word_addr, reset_vector;
	wire [8:0]  page_select_bits;
	wire [5:0]  word_in_page_bits;
	wire [7:0]  addr_pointer_high, addr_pointer_low, store_lock_data;
	wire [1:0]  store_op;
	integer     err_count = 0, checks = 0, cyc = 0;
	bfp_boot_flash_protection uut (.*);
	bfp_cpu_model cpu (.*);
	initial forever #5 pclk = ~pclk;
	task chk(input [31:0] got, input [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (err_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// a hang is cut short; the run needs under a hundred cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			stop_test;
		end
	end
	// straps are only sampled on reset release
	task boot(input [1:0] a, input [1:0] b, input f);
		@(posedge pclk);
		{presetn, nv_app_lock, nv_boot_lock, nv_boot_reset_select_fuse} <= {1'b0, a, b, f};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		{rd, se} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	// answer code: 2'b10 granted, 2'b01 refused
	task op(input [14:0] pc, input [15:0] p, input ld, input [1:0] o, input [1:0] e);
		cpu.issue(pc, p, ld, o, 8'hf0);
		chk(ld ? {load_grant, load_refused} : {store_grant, store_refused}, e);
	endtask
	initial begin
		boot(2'b11, 2'b11, 1'b1);
		chk(reset_vector, `BFP_RESET_VECTOR);
		op(15'h1c00, 16'h0102, 0, `BFP_OP_ERASE, 2'b10);
		chk({page_select_bits, word_in_page_bits}, 15'h0081);
		op(15'h1c00, 16'h0102, 0, `BFP_OP_WRITE, 2'b10);
		op(15'h1c00, 16'h3a01, 0, `BFP_OP_LOAD_BUF, 2'b10);
		op(15'h0010, 16'h0102, 0, `BFP_OP_WRITE, 2'b01);
		op(15'h1c00, 16'h0105, 1, 0, 2'b10);
		chk({load_word_addr, load_byte_high}, 16'h0105);
		boot(2'b10, 2'b10, 1'b0);
		chk(reset_vector, `BFP_BOOT_START);
		op(15'h1c00, 16'h0102, 0, `BFP_OP_WRITE, 2'b01);
		op(15'h1c00, 16'h3a00, 0, `BFP_OP_WRITE, 2'b01);
		op(15'h1c00, 16'h0102, 1, 0, 2'b10);
		op(15'h0010, 16'h3a00, 1, 0, 2'b10);
		boot(2'b01, 2'b01, 1'b1);
		op(15'h1c00, 16'h0102, 0, `BFP_OP_WRITE, 2'b10);
		op(15'h1c00, 16'h3a00, 0, `BFP_OP_WRITE, 2'b10);
		cpu_ivec_in_boot <= 1'b0;
		op(15'h1c00, 16'h0102, 1, 0, 2'b01);
		chk(irq_block, 1'b1);
		cpu_ivec_in_boot <= 1'b1;
		op(15'h0010, 16'h3a00, 1, 0, 2'b01);
		chk(irq_block, 1'b1);
		boot(2'b11, 2'b11, 1'b1);
		op(15'h1c00, 16'hffff, 0, `BFP_OP_LOCK, 2'b10);
		op(15'h1c00, 16'h0102, 0, `BFP_OP_WRITE, 2'b01);
		apb(1, `BFP_REG_LOCK, 32'hffffffff);
		apb(0, `BFP_REG_LOCK, 0);
		chk(rd[7:0], 8'hf0);
		apb(1, `BFP_REG_ERASE, `BFP_ERASE_KEY);
		apb(0, `BFP_REG_LOCK, 0);
		chk(rd[5:0], 6'h3f);
		apb(1, `BFP_REG_FUSE, 0);
		apb(0, `BFP_REG_FUSE, 0);
		chk({rd[0], reset_vector}, 16'h8000);
		apb(0, 12'h010, 0);
		chk(se, 1'b1);
		stop_test;
	end
endmodule
bind bfp_boot_flash_protection bfp_chk chk (.*);

// ---- verilog/bfp_boot_flash_protection.v ----
// access checker and address logic for boot flash self-programming
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "bfp_defines.vh"

module bfp_boot_flash_protection (
	input  wire                    pclk,
	input  wire                    presetn,
	// apb slave
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [11:0]             paddr,
	input  wire [31:0]             pwdata,
	output wire                    pready,
	output wire                    pslverr,
	output reg  [31:0]             prdata,
	// nonvolatile straps, sampled at reset release
	input  wire [1:0]              nv_app_lock,
	input  wire [1:0]              nv_boot_lock,
	input  wire [1:0]              nv_gen_lock,
	input  wire                    nv_boot_reset_select_fuse,
	// cpu side
	input  wire [`BFP_WADDR_W-1:0] cpu_pc,
	input  wire                    cpu_ivec_in_boot,
	input  wire [7:0]              addr_pointer_high,
	input  wire [7:0]              addr_pointer_low,
	input  wire                    store_program_memory_instr,
	input  wire [`BFP_OP_W-1:0]    store_op,
	input  wire [7:0]              store_lock_data,
	input  wire                    load_instr,
	// results
	output reg                     store_grant,
	output reg                     store_refused,
	output reg  [`BFP_PAGE_W-1:0]  page_select_bits,
	output reg  [`BFP_WORD_BITS-1:0] word_in_page_bits,
	output reg                     load_grant,
	output reg                     load_refused,
	output reg  [`BFP_WADDR_W-1:0] load_word_addr,
	output reg                     load_byte_high,
	output wire                    irq_block,
	output wire [`BFP_WADDR_W-1:0] reset_vector
);

	// section test, shared by the pc and the pointer checks
	function in_boot;
		input [`BFP_WADDR_W-1:0] a;
		begin
			in_boot = (a >= `BFP_BOOT_START);
		end
	endfunction

	// ==========================================================
	// lock and fuse state
	reg  [1:0] app_lock_q;
	reg  [1:0] boot_lock_q;
	reg  [1:0] gen_lock_q;
	reg        fuse_q;
	reg        loaded_q;
	wire       app_lock_upper     = app_lock_q[1];
	wire       app_lock_lower     = app_lock_q[0];
	wire       bootsec_lock_upper = boot_lock_q[1];
	wire       bootsec_lock_lower = boot_lock_q[0];

	wire       wr_en   = psel & penable & pwrite;
	wire       erase_w = wr_en & (paddr == `BFP_REG_ERASE) & (pwdata == `BFP_ERASE_KEY);

	// ==========================================================
	// pointer split and section decode
	wire [`BFP_PTR_W-1:0]   zptr  = {addr_pointer_high, addr_pointer_low};
	wire [`BFP_WADDR_W-1:0] zword = zptr[`BFP_PTR_W-1:1];
	wire pc_boot  = in_boot(cpu_pc);
	wire ptr_boot = in_boot(zword);
	wire is_lock  = (store_op == `BFP_OP_LOCK);

	// store checks: only from boot section, section write locks apply
	// only the lower bit guards writes; the upper bit alone (mode 4) leaves stores free
	wire app_wr_block  = (app_lock_lower == `BFP_PROGRAMMED);
	wire boot_wr_block = (bootsec_lock_lower == `BFP_PROGRAMMED);
	// general lock bits take no part in these checks
	wire store_ok = pc_boot & (is_lock | (ptr_boot ? ~boot_wr_block : ~app_wr_block));

	// load checks: cross-section reads blocked by upper lock bits
	wire load_ok = ptr_boot ? (pc_boot | (bootsec_lock_upper != `BFP_PROGRAMMED))
	                        : (~pc_boot | (app_lock_upper != `BFP_PROGRAMMED));

	// ==========================================================
	// lock state: sampled after reset, programmed by lock stores, erased by chip erase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			app_lock_q  <= `BFP_LOCK_ERASED;
			boot_lock_q <= `BFP_LOCK_ERASED;
			gen_lock_q  <= `BFP_LOCK_ERASED;
			fuse_q      <= 1'b1;
			loaded_q    <= 1'b0;
		end else if (!loaded_q) begin
			app_lock_q  <= nv_app_lock;
			boot_lock_q <= nv_boot_lock;
			gen_lock_q  <= nv_gen_lock;
			fuse_q      <= nv_boot_reset_select_fuse;
			loaded_q    <= 1'b1;
		end else if (erase_w) begin
			app_lock_q  <= `BFP_LOCK_ERASED;
			boot_lock_q <= `BFP_LOCK_ERASED;
			gen_lock_q  <= `BFP_LOCK_ERASED;
		end else if (store_program_memory_instr & is_lock & store_ok) begin
			// bits can only go to programmed (0) here
			gen_lock_q  <= gen_lock_q & store_lock_data[1:0];
			app_lock_q  <= app_lock_q & store_lock_data[3:2];
			boot_lock_q <= boot_lock_q & store_lock_data[5:4];
		end
	end

	// ==========================================================
	// store and load results, address latched at start
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_grant       <= 1'b0;
			store_refused     <= 1'b0;
			page_select_bits  <= {`BFP_PAGE_W{1'b0}};
			word_in_page_bits <= {`BFP_WORD_BITS{1'b0}};
			load_grant        <= 1'b0;
			load_refused      <= 1'b0;
			load_word_addr    <= {`BFP_WADDR_W{1'b0}};
			load_byte_high    <= 1'b0;
		end else begin
			store_grant   <= store_program_memory_instr & loaded_q & store_ok;
			store_refused <= store_program_memory_instr & ~(loaded_q & store_ok);
			if (store_program_memory_instr & loaded_q & store_ok & ~is_lock) begin
				page_select_bits  <= zword[`BFP_WADDR_W-1:`BFP_WORD_BITS];
				word_in_page_bits <= zword[`BFP_WORD_BITS-1:0];
			end
			load_grant   <= load_instr & loaded_q & load_ok;
			load_refused <= load_instr & ~(loaded_q & load_ok);
			if (load_instr) begin
				load_word_addr <= zword;
				load_byte_high <= zptr[0];
			end
		end
	end

	// interrupt gating and reset vector
	assign irq_block = loaded_q &
		((~pc_boot & cpu_ivec_in_boot & (app_lock_upper == `BFP_PROGRAMMED)) |
		 (pc_boot & ~cpu_ivec_in_boot & (bootsec_lock_upper == `BFP_PROGRAMMED)));
	assign reset_vector = (fuse_q == `BFP_PROGRAMMED) ? `BFP_BOOT_START : `BFP_RESET_VECTOR;

	// ==========================================================
	// apb slave: zero wait states, unmapped reads zero and error
	wire mapped = (paddr == `BFP_REG_LOCK) | (paddr == `BFP_REG_FUSE) |
	              (paddr == `BFP_REG_STATUS) | (paddr == `BFP_REG_ERASE);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// read mux; fuse register is read only, processor cannot alter it
	always @* begin
		case (paddr)
			`BFP_REG_LOCK:   prdata = {24'h000000, 2'b11, boot_lock_q, app_lock_q, gen_lock_q};
			`BFP_REG_FUSE:   prdata = {31'h00000000, fuse_q};
			`BFP_REG_STATUS: prdata = {28'h0000000, irq_block, load_refused,
			                           store_refused, loaded_q};
			default:         prdata = 32'h00000000;
		endcase
	end

endmodule
